// ---- samc_top.sv ----
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Descriptor base two-bit field selects paging
// - Paged descriptor segment uses its page table
// - Completed walk caches origin, segment, page
// - Associative hit supplies origin without walk
// - Three modes; all instructions in absolute, master
// - Privileged operations only in absolute, master
// - Any fault enters absolute mode
// - Master may enter absolute under guard
// - Interrupt inhibit honoured except slave mode
// - Absolute mode: absolute unless a req_rel fetch, optional relative operands
// - Else relative; mode from fetch segment
// - Master mode never uses absolute addresses
// - Slave enters master segment only at zero
// - Slave privileged instruction raises fault
// - Segment type: master, slave, data, execute-only
// - No instruction fetch from data segment
// - Execute-only segment refuses operand access
// - Execute-only entry at zero, else slave-like
// - Write permit and master access bits
// - Two bits select nonpaged, 64, 1024 paging
// - Word number 10 or 6 bits
// - Page table origin plus page; origin plus word
// - Privileged clear of all associative entries
module samc_top #(
	parameter int NUM_AM = 8
) (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	// AHB-Lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	// Translation request from the processor
	input  wire logic                        req_valid,
	input  wire logic [1:0]                  req_kind,
	input  wire logic [samc_pkg::SEG_W-1:0]  req_seg,
	input  wire logic [samc_pkg::OFF_W-1:0]  req_off,
	input  wire logic                        req_rel,
	input  wire logic                        req_xfer,
	input  wire logic                        req_priv,
	input  wire logic                        req_inhibit,
	output logic                             req_ready,
	// Translation answer
	output logic                             rsp_valid,
	output logic      [samc_pkg::ABS_W-1:0]  rsp_addr,
	output logic      [3:0]                  rsp_fault,
	output logic                             int_inhibit,
	// Mode control and state
	input  wire logic                        fault_take,
	input  wire logic                        abs_enter,
	output logic      [1:0]                  mode,
	// Table walk memory reads
	output logic                             mem_rd,
	output logic      [samc_pkg::ABS_W-1:0]  mem_addr,
	input  wire logic                        mem_ack,
	input  wire logic [samc_pkg::WORD_W-1:0] mem_rdata
);

	localparam int IDX_W = (NUM_AM > 1) ? $clog2(NUM_AM) : 1;

	// ----------------------------------------------------------------
	// Address partitioning helpers
	// ----------------------------------------------------------------
	// Page number of an offset for a paging code
	function automatic logic [samc_pkg::OFF_W-1:0] page_of(
		input logic [1:0]                 pg,
		input logic [samc_pkg::OFF_W-1:0] off
	);
		page_of = (pg == samc_pkg::PG_SMALL) ? off >> samc_pkg::SMALL_WORD_BITS
			: (pg == samc_pkg::PG_LARGE) ? off >> samc_pkg::LARGE_WORD_BITS : '0;
	endfunction

	// Word number of an offset; a nonpaged segment keeps the whole offset
	function automatic logic [samc_pkg::ABS_W-1:0] word_of(
		input logic [1:0]                 pg,
		input logic [samc_pkg::OFF_W-1:0] off
	);
		word_of = samc_pkg::ABS_W'(off - (page_of(pg, off) << ((pg == samc_pkg::PG_LARGE) ?
			samc_pkg::LARGE_WORD_BITS : samc_pkg::SMALL_WORD_BITS)));
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	samc_pkg::samc_state_type    st_q;
	logic [1:0]                  mode_q;
	logic [samc_pkg::ABS_W-1:0]  dbr_org_q;
	logic [1:0]                  dbr_pg_q;
	logic                        absrel_q;
	logic                        refused_q;
	logic [3:0]                  last_fault_q;
	logic [1:0]                  kind_q;
	logic [samc_pkg::SEG_W-1:0]  seg_q;
	logic [samc_pkg::OFF_W-1:0]  off_q;
	logic                        rel_q;
	logic                        xfer_q;
	logic                        priv_q;
	logic                        inhibit_q;
	logic [samc_pkg::CTL_W-1:0]  ctl_q;
	logic [samc_pkg::ABS_W-1:0]  org_q;
	logic                        abs_path_q;
	logic                        mem_rd_q;
	logic [samc_pkg::ABS_W-1:0]  mem_addr_q;
	logic                        rsp_valid_q;
	logic [samc_pkg::ABS_W-1:0]  rsp_addr_q;
	logic [3:0]                  rsp_fault_q;
	logic                        int_inhibit_q;
	logic                        req_ready_q;
	logic [31:0]                 hrdata_q;
	logic                        ap_valid_q;
	logic [7:0]                  ap_addr_q;

	// Associative memory
	logic                        am_vld_q  [NUM_AM];
	logic [samc_pkg::SEG_W-1:0]  am_seg_q  [NUM_AM];
	logic [samc_pkg::OFF_W-1:0]  am_page_q [NUM_AM];
	logic [samc_pkg::ABS_W-1:0]  am_org_q  [NUM_AM];
	logic [samc_pkg::CTL_W-1:0]  am_ctl_q  [NUM_AM];
	logic [IDX_W-1:0]            am_ptr_q;
	logic [NUM_AM-1:0]           am_match;
	logic                        am_hit;
	logic [IDX_W-1:0]            am_idx;
	logic                        am_wr;
	logic                        am_clr;

	// Bus decode
	logic                        ap_take;
	logic                        wr_dbr;
	logic                        wr_ctrl;
	logic                        wr_stat;
	logic                        is_slave;

	// Walk and check terms
	logic                        accept;
	logic                        abs_path;
	logic [samc_pkg::CTL_W-1:0]  sdw_ctl;
	logic [samc_pkg::ABS_W-1:0]  rd_org;
	logic [1:0]                  seg_pg;
	logic [1:0]                  seg_type;
	logic [3:0]                  fault;
	logic [samc_pkg::ABS_W-1:0]  final_addr;

	assign is_slave = (mode_q == samc_pkg::MODE_SLAVE);
	assign accept   = (st_q == samc_pkg::ST_IDLE) && req_valid;
	assign sdw_ctl  = mem_rdata[samc_pkg::SDW_CTL_LSB +: samc_pkg::CTL_W];
	assign rd_org   = mem_rdata[samc_pkg::ORG_LSB +: samc_pkg::ABS_W];
	assign seg_pg   = ctl_q[samc_pkg::CTL_PG_LSB +: 2];
	assign seg_type = ctl_q[samc_pkg::CTL_TYPE_LSB +: 2];

	// fetch absolute unless req_rel, operands relative only when enabled
	assign abs_path = (mode_q == samc_pkg::MODE_ABS) &&
		((kind_q == samc_pkg::ACC_FETCH) ? !rel_q : !absrel_q);

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	assign ap_take = hsel && hready && (htrans == samc_pkg::HTRANS_NONSEQ);
	assign wr_dbr  = ap_valid_q && (ap_addr_q == samc_pkg::REG_DBR);
	assign wr_ctrl = ap_valid_q && (ap_addr_q == samc_pkg::REG_CTRL);
	assign wr_stat = ap_valid_q && (ap_addr_q == samc_pkg::REG_STATUS);

	// Address phase capture and read data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ap_valid_q <= 1'b0;
			ap_addr_q  <= 8'h00;
			hrdata_q   <= 32'h00000000;
		end else begin
			ap_valid_q <= ap_take && hwrite;
			ap_addr_q  <= haddr[7:0];
			if (ap_take && !hwrite) begin
				if (haddr[7:0] == samc_pkg::REG_DBR) begin
					hrdata_q <= {6'h00, dbr_pg_q, dbr_org_q};
				end else if (haddr[7:0] == samc_pkg::REG_CTRL) begin
					hrdata_q <= {31'h00000000, absrel_q};
				end else if (haddr[7:0] == samc_pkg::REG_STATUS) begin
					hrdata_q <= {20'h00000, last_fault_q, 4'h0, refused_q,
						(st_q != samc_pkg::ST_IDLE), mode_q};
				end else begin
					hrdata_q <= 32'h00000000;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dbr_org_q <= samc_pkg::DBR_ORG_RST;
			dbr_pg_q  <= samc_pkg::DBR_PG_RST;
			absrel_q  <= 1'b0;
		end else begin
			if (wr_dbr && !is_slave) begin
				dbr_org_q <= hwdata[samc_pkg::ABS_W-1:0];
				dbr_pg_q  <= hwdata[samc_pkg::DBR_PG_LSB +: 2];
			end
			if (wr_ctrl) begin
				absrel_q <= hwdata[samc_pkg::CTRL_ABSREL_BIT];
			end
		end
	end

	// associative clear, refused in slave mode
	assign am_clr = wr_ctrl && hwdata[samc_pkg::CTRL_AMCLR_BIT] && !is_slave;

	// Sticky refusal flag, a new refusal beats a clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			refused_q <= 1'b0;
		end else if (is_slave && (wr_dbr || (wr_ctrl && hwdata[samc_pkg::CTRL_AMCLR_BIT]))) begin
			refused_q <= 1'b1;
		end else if (wr_stat && hwdata[samc_pkg::STAT_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Associative memory
	// ----------------------------------------------------------------
	// match on segment and page number
	generate
		for (genvar g = 0; g < NUM_AM; g++) begin : gen_match
			assign am_match[g] = am_vld_q[g] && (am_seg_q[g] == seg_q) &&
				((am_ctl_q[g][samc_pkg::CTL_PG_LSB +: 2] == samc_pkg::PG_NONE) ||
				(am_page_q[g] == page_of(am_ctl_q[g][samc_pkg::CTL_PG_LSB +: 2], off_q)));
		end
	endgenerate

	// Lowest matching entry wins
	always_comb begin
		am_hit = 1'b0;
		am_idx = '0;
		for (int i = 0; i < NUM_AM; i++) begin
			if (am_match[i] && !am_hit) begin
				am_hit = 1'b1;
				am_idx = IDX_W'(i);
			end
		end
	end

	assign am_wr = ((st_q == samc_pkg::ST_SDW) && mem_ack &&
		(sdw_ctl[samc_pkg::CTL_PG_LSB +: 2] == samc_pkg::PG_NONE)) ||
		((st_q == samc_pkg::ST_PDW) && mem_ack);

	always_ff @(posedge ref_clk) begin
		if (!rst_n || am_clr) begin
			am_ptr_q <= '0;
			for (int i = 0; i < NUM_AM; i++) begin
				am_vld_q[i] <= 1'b0;
			end
		end else if (am_wr) begin
			am_vld_q[am_ptr_q]  <= 1'b1;
			am_seg_q[am_ptr_q]  <= seg_q;
			am_page_q[am_ptr_q] <= page_of(seg_pg, off_q);
			am_ptr_q            <= (am_ptr_q == IDX_W'(NUM_AM - 1)) ? '0 : am_ptr_q + 1'b1;
			am_org_q[am_ptr_q]  <= rd_org;
			am_ctl_q[am_ptr_q]  <= (st_q == samc_pkg::ST_SDW) ? sdw_ctl : ctl_q;
		end
	end

	// ----------------------------------------------------------------
	// Translation walk
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q        <= samc_pkg::ST_IDLE;
			req_ready_q <= 1'b1;
			mem_rd_q    <= 1'b0;
			mem_addr_q  <= '0;
			ctl_q       <= '0;
			org_q       <= '0;
		end else begin
			case (st_q)
				samc_pkg::ST_IDLE: begin
					if (accept) begin
						kind_q      <= req_kind;
						seg_q       <= req_seg;
						off_q       <= req_off;
						rel_q       <= req_rel;
						xfer_q      <= req_xfer;
						priv_q      <= req_priv;
						inhibit_q   <= req_inhibit;
						req_ready_q <= 1'b0;
						st_q        <= samc_pkg::ST_LOOK;
					end
				end
				samc_pkg::ST_LOOK: begin
					abs_path_q <= abs_path;
					if (abs_path) begin
						st_q <= samc_pkg::ST_CHECK;
					end else if (am_hit) begin
						org_q <= am_org_q[am_idx];
						ctl_q <= am_ctl_q[am_idx];
						st_q  <= samc_pkg::ST_CHECK;
					end else if (dbr_pg_q == samc_pkg::PG_SMALL || dbr_pg_q == samc_pkg::PG_LARGE) begin
						mem_rd_q   <= 1'b1;
						mem_addr_q <= dbr_org_q + samc_pkg::ABS_W'(page_of(dbr_pg_q, seg_q));
						st_q       <= samc_pkg::ST_DPDW;
					end else begin
						mem_rd_q   <= 1'b1;
						mem_addr_q <= dbr_org_q + samc_pkg::ABS_W'(seg_q);
						st_q       <= samc_pkg::ST_SDW;
					end
				end
				samc_pkg::ST_DPDW: begin
					if (mem_ack) begin
						mem_addr_q <= rd_org + word_of(dbr_pg_q, seg_q);
						st_q       <= samc_pkg::ST_SDW;
					end
				end
				samc_pkg::ST_SDW: begin
					if (mem_ack) begin
						ctl_q <= sdw_ctl;
						org_q <= rd_org;
						// paging code decides a second read
						if (sdw_ctl[samc_pkg::CTL_PG_LSB +: 2] == samc_pkg::PG_NONE) begin
							mem_rd_q <= 1'b0;
							st_q     <= samc_pkg::ST_CHECK;
						end else begin
							mem_addr_q <= rd_org + samc_pkg::ABS_W'(
								page_of(sdw_ctl[samc_pkg::CTL_PG_LSB +: 2], off_q));
							st_q       <= samc_pkg::ST_PDW;
						end
					end
				end
				samc_pkg::ST_PDW: begin
					if (mem_ack) begin
						mem_rd_q <= 1'b0;
						org_q    <= rd_org;
						st_q     <= samc_pkg::ST_CHECK;
					end
				end
				samc_pkg::ST_CHECK: begin
					req_ready_q <= 1'b1;
					st_q        <= samc_pkg::ST_IDLE;
				end
				default: begin
					mem_rd_q    <= 1'b0;
					req_ready_q <= 1'b1;
					st_q        <= samc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Access checks and final address
	// ----------------------------------------------------------------
	always_comb begin
		fault = samc_pkg::F_NONE;
		if (priv_q && is_slave) begin
			fault = samc_pkg::F_PRIV;
		end else if (abs_path_q) begin
			fault = samc_pkg::F_NONE;
		end else if (kind_q == samc_pkg::ACC_FETCH && seg_type == samc_pkg::SEG_DATA) begin
			fault = samc_pkg::F_FETCH_DATA;
		end else if (kind_q != samc_pkg::ACC_FETCH && seg_type == samc_pkg::SEG_EXEC) begin
			fault = samc_pkg::F_EXEC_OPND;
		end else if (xfer_q && is_slave && off_q != '0 &&
			(seg_type == samc_pkg::SEG_MASTER || seg_type == samc_pkg::SEG_EXEC)) begin
			fault = samc_pkg::F_ENTRY;
		end else if (kind_q == samc_pkg::ACC_WRITE && !ctl_q[samc_pkg::CTL_WP_BIT]) begin
			fault = samc_pkg::F_WRITE;
		end else if (ctl_q[samc_pkg::CTL_MA_BIT] && is_slave) begin
			fault = samc_pkg::F_MASTER_ACC;
		end
		// relative address from origin and word
		if (abs_path_q) begin
			final_addr = samc_pkg::ABS_W'(off_q);
		end else begin
			final_addr = org_q + word_of(seg_pg, off_q);
		end
	end

	// Answer to the processor
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rsp_valid_q   <= 1'b0;
			rsp_addr_q    <= '0;
			rsp_fault_q   <= samc_pkg::F_NONE;
			int_inhibit_q <= 1'b0;
			last_fault_q  <= samc_pkg::F_NONE;
		end else begin
			rsp_valid_q <= (st_q == samc_pkg::ST_CHECK);
			if (st_q == samc_pkg::ST_CHECK) begin
				rsp_addr_q  <= final_addr;
				rsp_fault_q <= fault;
				int_inhibit_q <= inhibit_q && !is_slave;
				if (fault != samc_pkg::F_NONE) begin
					last_fault_q <= fault;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Processor mode
	// ----------------------------------------------------------------
	// three modes, absolute after reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_q <= samc_pkg::MODE_ABS;
		end else if (fault_take || (st_q == samc_pkg::ST_CHECK && fault != samc_pkg::F_NONE)) begin
			mode_q <= samc_pkg::MODE_ABS;
		end else if (abs_enter && mode_q == samc_pkg::MODE_MASTER) begin
			mode_q <= samc_pkg::MODE_ABS;
		end else if (st_q == samc_pkg::ST_CHECK && kind_q == samc_pkg::ACC_FETCH && !abs_path_q) begin
			mode_q <= (seg_type == samc_pkg::SEG_MASTER) ? samc_pkg::MODE_MASTER
				: samc_pkg::MODE_SLAVE;
		end
	end

	// Output drive
	assign hrdata      = hrdata_q;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign req_ready   = req_ready_q;
	assign rsp_valid   = rsp_valid_q;
	assign rsp_addr    = rsp_addr_q;
	assign rsp_fault   = rsp_fault_q;
	assign int_inhibit = int_inhibit_q;
	assign mode        = mode_q;
	assign mem_rd      = mem_rd_q;
	assign mem_addr    = mem_addr_q;

endmodule
`default_nettype wire

// ---- samc_pkg.sv ----
package samc_pkg;

	// ----------------------------------------------------------------
	// Address widths and table word layout
	// ----------------------------------------------------------------
	localparam int SEG_W  = 18;
	localparam int OFF_W  = 18;
	localparam int ABS_W  = 24;
	localparam int WORD_W = 32;
	localparam int CTL_W  = 6;

	// Descriptor and page word fields
	localparam int ORG_LSB     = 0;
	localparam int SDW_CTL_LSB = 24;

	// Control field positions inside the cached control bits
	localparam int CTL_PG_LSB   = 0;
	localparam int CTL_TYPE_LSB = 2;
	localparam int CTL_WP_BIT   = 4;
	localparam int CTL_MA_BIT   = 5;

	// Word number widths for the two page sizes
	localparam int SMALL_WORD_BITS = 6;
	localparam int LARGE_WORD_BITS = 10;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PG_NONE  = 2'b00,
		PG_SMALL = 2'b01,
		PG_LARGE = 2'b10
	} samc_paging_type;

	typedef enum logic [1:0] {
		SEG_MASTER = 2'b00,
		SEG_SLAVE  = 2'b01,
		SEG_DATA   = 2'b10,
		SEG_EXEC   = 2'b11
	} samc_seg_type;

	typedef enum logic [1:0] {
		MODE_ABS    = 2'b00,
		MODE_MASTER = 2'b01,
		MODE_SLAVE  = 2'b10
	} samc_mode_type;

	typedef enum logic [1:0] {
		ACC_FETCH = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b10
	} samc_acc_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOOK  = 3'b001,
		ST_DPDW  = 3'b010,
		ST_SDW   = 3'b011,
		ST_PDW   = 3'b100,
		ST_CHECK = 3'b101
	} samc_state_type;

	// Fault codes
	localparam logic [3:0] F_NONE       = 4'h0;
	localparam logic [3:0] F_PRIV       = 4'h1;
	localparam logic [3:0] F_FETCH_DATA = 4'h2;
	localparam logic [3:0] F_EXEC_OPND  = 4'h3;
	localparam logic [3:0] F_WRITE      = 4'h4;
	localparam logic [3:0] F_MASTER_ACC = 4'h5;
	localparam logic [3:0] F_ENTRY      = 4'h6;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_DBR    = 8'h00;
	localparam logic [7:0] REG_CTRL   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	localparam int DBR_PG_LSB       = 24;
	localparam int CTRL_ABSREL_BIT  = 0;
	localparam int CTRL_AMCLR_BIT   = 1;
	localparam int STAT_MODE_LSB    = 0;
	localparam int STAT_BUSY_BIT    = 2;
	localparam int STAT_REFUSED_BIT = 3;
	localparam int STAT_FAULT_LSB   = 8;

	localparam logic [ABS_W-1:0] DBR_ORG_RST = 24'h000000;
	localparam logic [1:0]       DBR_PG_RST  = 2'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// ---- samc_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module samc_asserts (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Request side
	input wire logic        req_valid,
	input wire logic [1:0]  req_kind,
	input wire logic [17:0] req_off,
	input wire logic        req_rel,
	input wire logic        req_priv,
	input wire logic        req_inhibit,
	input wire logic        req_ready,
	// Answer and mode
	input wire logic        rsp_valid,
	input wire logic [23:0] rsp_addr,
	input wire logic [3:0]  rsp_fault,
	input wire logic        int_inhibit,
	input wire logic        fault_take,
	input wire logic        abs_enter,
	input wire logic [1:0]  mode,
	// Table reads
	input wire logic        mem_rd,
	input wire logic [23:0] mem_addr,
	input wire logic        mem_ack
);
	logic        abs_q;
	logic        slv_q;
	logic        prv_q;
	logic        inh_q;
	logic [17:0] off_q;
	// Note what each taken request asked for
	always_ff @(posedge ref_clk) begin
		if (req_valid && req_ready) begin
			abs_q <= mode == 2'h0 && req_kind == 2'h0 && !req_rel;
			slv_q <= mode == 2'h2;
			prv_q <= req_priv;
			inh_q <= req_inhibit;
			off_q <= req_off;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_abs_take;
		req_valid && req_ready && mode == 2'h0 && req_kind == 2'h0 && !req_rel;
	endsequence
	sequence s_quick_answer;
		!mem_rd [*3] ##[0:1] rsp_valid;
	endsequence
	property p_abs_quick;
		s_abs_take |=> s_quick_answer;
	endproperty
	a_abs_quick: assert property (p_abs_quick)
		else $error("absolute request walked tables");
	property p_abs_addr;
		rsp_valid && abs_q |-> rsp_addr == {6'h0, off_q} && rsp_fault == 4'h0 && int_inhibit == inh_q;
	endproperty
	a_abs_addr: assert property (p_abs_addr)
		else $error("absolute answer wrong");
	property p_walk_hold;
		mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr);
	endproperty
	a_walk_hold: assert property (p_walk_hold)
		else $error("table read dropped");
	property p_fault_abs;
		rsp_valid && rsp_fault != 4'h0 |-> mode == 2'h0;
	endproperty
	a_fault_abs: assert property (p_fault_abs)
		else $error("fault left mode");
	property p_fault_take;
		fault_take |=> mode == 2'h0;
	endproperty
	a_fault_take: assert property (p_fault_take)
		else $error("taken fault left mode");
	property p_master_exit;
		abs_enter && mode == 2'h1 && !fault_take |=> mode == 2'h0;
	endproperty
	a_master_exit: assert property (p_master_exit)
		else $error("master did not enter absolute");
	property p_slave_guard;
		abs_enter && mode == 2'h2 && req_ready && !req_valid && !fault_take |=> mode == 2'h2;
	endproperty
	a_slave_guard: assert property (p_slave_guard)
		else $error("slave entered absolute");
	property p_slave_priv;
		rsp_valid && slv_q && prv_q |-> rsp_fault == 4'h1;
	endproperty
	a_slave_priv: assert property (p_slave_priv)
		else $error("slave privileged without fault");
	property p_slave_inh;
		rsp_valid && slv_q && mode == 2'h2 |-> !int_inhibit;
	endproperty
	a_slave_inh: assert property (p_slave_inh)
		else $error("slave inhibit honoured");
endmodule
bind samc_top samc_asserts u_chk (.ref_clk, .rst_n, .req_valid, .req_kind,
	.req_off, .req_rel, .req_priv, .req_inhibit, .req_ready, .rsp_valid, .rsp_addr, .rsp_fault,
	.int_inhibit, .fault_take, .abs_enter, .mode, .mem_rd, .mem_addr, .mem_ack);
`default_nettype wire

// ---- samc_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module samc_mem_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Table read port
	input  wire logic        mem_rd,
	input  wire logic [23:0] mem_addr,
	input  wire logic [1:0]  wait_n,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [31:0] words [logic [23:0]];
	logic [1:0]  cnt_q;
	int          n_rd;
	// Ack a held read after wait_n cycles; data scrambled off the ack
	always_ff @(posedge ref_clk) begin
		mem_ack <= 1'h0;
		mem_rdata <= ~mem_rdata;
		if (!rst_n) begin
			cnt_q <= 2'h0;
			n_rd <= 0;
			mem_rdata <= 32'hA5A5A5A5;
		end else if (mem_rd && !mem_ack) begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == wait_n) begin
				cnt_q <= 2'h0;
				mem_ack <= 1'h1;
				mem_rdata <= words[mem_addr];
				n_rd <= n_rd + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- segment_access_mode_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module segment_access_mode_control_tb;
	logic        ref_clk = 1'h0, rst_n = 1'h0, hwrite = 1'h0, req_valid = 1'h0, req_rel = 1'h0;
	logic        req_xfer = 1'h0, req_priv = 1'h0, req_inhibit = 1'h0, fault_take = 1'h0;
	logic        abs_enter = 1'h0, hreadyout, hresp, req_ready, rsp_valid, int_inhibit, mem_rd;
	logic        mem_ack;
	logic [1:0]  htrans = 2'h0, req_kind = 2'h0, wait_n = 2'h0, mode;
	logic [17:0] req_seg = 18'h0, req_off = 18'h0;
	logic [23:0] rsp_addr, mem_addr;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_rdata, rd;
	logic [3:0]  rsp_fault;
	int          errors = 0, n_checks = 0, n;
	// Block under test and its table memory
	samc_top #(.NUM_AM(2)) DUT (.ref_clk, .rst_n, .hsel(1'h1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req_valid,
		.req_kind, .req_seg, .req_off, .req_rel, .req_xfer, .req_priv, .req_inhibit, .req_ready,
		.rsp_valid, .rsp_addr, .rsp_fault, .int_inhibit, .fault_take, .abs_enter, .mode, .mem_rd,
		.mem_addr, .mem_ack, .mem_rdata);
	samc_mem_model mem (.ref_clk, .rst_n, .mem_rd, .mem_addr, .wait_n, .mem_ack, .mem_rdata);
	// Clock
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Single word bus transfer; read data lands in rd
	task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge ref_clk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (!hreadyout);
		rd = hrdata;
	endtask
	// One translation, then fault and mode compared
	task automatic xc(logic [1:0] k, logic [17:0] s, o, logic r, x, p, logic [3:0] f, logic [1:0] m);
		{req_valid, req_kind, req_seg, req_off, req_rel, req_xfer, req_priv, req_inhibit} <=
			{1'h1, k, s, o, r, x, p, 1'h1};
		do @(posedge ref_clk); while (!req_ready);
		req_valid <= 1'h0;
		do @(posedge ref_clk); while (!rsp_valid);
		chk("fault", f, rsp_fault);
		chk("mode", m, mode);
	endtask
	// Relative fetch into a slave or execute-only segment, no fault
	task automatic rf(logic [17:0] s, o);
		xc(2'h0, s, o, 1'h1, 1'h0, 1'h0, 4'h0, 2'h2);
	endtask
	task automatic pulse(logic te, logic ae, logic [1:0] m);
		fault_take <= te;
		abs_enter <= ae;
		@(posedge ref_clk);
		fault_take <= 1'h0;
		abs_enter <= 1'h0;
		@(posedge ref_clk);
		chk("mode", m, mode);
	endtask
	task automatic t_reset;
		chk("ready", 1'h1, req_ready);
		ahb(1'h1, 8'h0C, 32'hFFFFFFFF);
		ahb(1'h0, 8'h0C, 32'h0);
		chk("unmapped", 32'h0, rd);
		ahb(1'h0, 8'h08, 32'h0);
		chk("status", 32'h0, rd);
	endtask
	task automatic t_abs;
		xc(2'h0, 18'h0, 18'h00123, 1'h0, 1'h0, 1'h1, 4'h0, 2'h0);
		chk("addr", 24'h000123, rsp_addr);
		chk("inhibit", 1'h1, int_inhibit);
		xc(2'h2, 18'h0, 18'h3FFFF, 1'h0, 1'h0, 1'h0, 4'h0, 2'h0);
		chk("addr", 24'h03FFFF, rsp_addr);
	endtask
	task automatic t_walk;
		ahb(1'h1, 8'h00, 32'h00001000);
		wait_n <= 2'h2;
		n = mem.n_rd;
		rf(18'h2, 18'h000C5);
		chk("addr", 24'h004005, rsp_addr);
		chk("reads", n + 2, mem.n_rd);
		rf(18'h2, 18'h000C9);
		chk("addr", 24'h004009, rsp_addr);
		chk("reads", n + 2, mem.n_rd);
		chk("inhibit", 1'h0, int_inhibit);
	endtask
	task automatic t_slave;
		ahb(1'h1, 8'h00, 32'h0000FFFF);
		ahb(1'h0, 8'h08, 32'h0);
		chk("status", 32'h0000000A, rd);
		ahb(1'h0, 8'h00, 32'h0);
		chk("dbr", 32'h00001000, rd);
		pulse(1'h0, 1'h1, 2'h2);
		xc(2'h0, 18'h2, 18'h000C5, 1'h0, 1'h0, 1'h1, 4'h1, 2'h0);
	endtask
	task automatic t_access;
		xc(2'h0, 18'h3, 18'h0, 1'h1, 1'h0, 1'h0, 4'h2, 2'h0);
		ahb(1'h1, 8'h04, 32'h1);
		xc(2'h1, 18'h4, 18'h0, 1'h0, 1'h0, 1'h0, 4'h3, 2'h0);
		rf(18'h7, 18'h0);
		xc(2'h2, 18'h7, 18'h5, 1'h0, 1'h0, 1'h0, 4'h0, 2'h2);
		chk("addr", 24'h009005, rsp_addr);
		xc(2'h2, 18'h2, 18'h0, 1'h0, 1'h0, 1'h0, 4'h4, 2'h0);
		rf(18'h7, 18'h0);
		xc(2'h1, 18'h5, 18'h0, 1'h0, 1'h0, 1'h0, 4'h5, 2'h0);
		rf(18'h7, 18'h0);
		xc(2'h0, 18'h6, 18'h4, 1'h0, 1'h1, 1'h0, 4'h6, 2'h0);
		rf(18'h7, 18'h0);
		xc(2'h0, 18'h4, 18'h1, 1'h0, 1'h1, 1'h0, 4'h6, 2'h0);
		rf(18'h7, 18'h0);
		xc(2'h0, 18'h4, 18'h0, 1'h0, 1'h1, 1'h0, 4'h0, 2'h2);
		xc(2'h0, 18'h6, 18'h0, 1'h0, 1'h1, 1'h0, 4'h0, 2'h1);
		xc(2'h0, 18'h6, 18'h3, 1'h0, 1'h0, 1'h0, 4'h0, 2'h1);
		chk("addr", 24'h008003, rsp_addr);
		pulse(1'h0, 1'h1, 2'h0);
	endtask
	task automatic t_clear;
		wait_n <= 2'h0;
		rf(18'h2, 18'h000C5);
		pulse(1'h1, 1'h0, 2'h0);
		ahb(1'h1, 8'h04, 32'h3);
		n = mem.n_rd;
		rf(18'h2, 18'h000C5);
		chk("reads", n + 2, mem.n_rd);
		rf(18'h7, 18'h0);
		rf(18'h4, 18'h0);
		rf(18'h7, 18'h1);
		chk("reads", n + 4, mem.n_rd);
		rf(18'h2, 18'h000C5);
		chk("reads", n + 6, mem.n_rd);
	endtask
	task automatic t_dpaged;
		pulse(1'h1, 1'h0, 2'h0);
		ahb(1'h1, 8'h00, 32'h01003000);
		ahb(1'h1, 8'h04, 32'h3);
		n = mem.n_rd;
		rf(18'h2, 18'h000C5);
		chk("addr", 24'h004005, rsp_addr);
		chk("reads", n + 3, mem.n_rd);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Tables, reset, then the scenarios
	initial begin
		mem.words[24'h001002] = 32'h05002000;
		mem.words[24'h002003] = 32'h00004000;
		mem.words[24'h002000] = 32'h00004800;
		mem.words[24'h001003] = 32'h08005000;
		mem.words[24'h001004] = 32'h0C006000;
		mem.words[24'h001005] = 32'h24007000;
		mem.words[24'h001006] = 32'h10008000;
		mem.words[24'h001007] = 32'h14009000;
		mem.words[24'h003000] = 32'h0000A000;
		mem.words[24'h00A002] = 32'h05002000;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		t_reset;
		t_abs;
		t_walk;
		t_slave;
		t_access;
		t_clear;
		t_dpaged;
		finish_test;
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		finish_test;
	end
endmodule
`default_nettype wire
